// ---- logic/eplc_loader.sv ----
// eplc_loader: copies configuration words into per-port config fields
// assumes: a word reader on clk answers each request with one valid pulse
//
// Operation
// (RQ1) The port 5 PHY word bits 4:0 go to PHY parameter 2 bits 12:8 at 7Ch.
// (RQ2) The port 5 PHY word bits 11:5 go to PHY parameter 3 bits 6:0 at 90h.
// (RQ3) The port 5 PHY word bit 12 goes to de-emphasis select, bit 6 at F0h.
// (RQ4) The port 5 PHY word bit 13 goes to compliance-to-detect, bit 11 at 78h.
// (RQ5) The port 5 PHY word bits 15:14 go to data count change select, 8Ch bits 9:8.
// (RQ6) The port 4 PHY word feeds compliance-to-detect and data count change select alike.
// (RQ7) Word 50h bit 0 goes to the port 0 no soft reset bit, bit 3 at 44h.
// (RQ8) Power-management word bits 3:1 go to auxiliary current, 40h bits 24:22.
// (RQ9) The D1 support bit, 40h bit 25, always reads 1 and is read only.
// (RQ10) The D2 support bit, 40h bit 26, always reads 1 and is read only.
// (RQ11) Power-management word bits 7:6 go to wake support for D2/D1, 40h bits 29:28.
// (RQ12) Word 51h bits 15:8 go to port 0 44h bits 31:24, read only data.
// (RQ13) Ports 1 to 3 take the same power-management layout from words 52h, 54h, 56h.
// (RQ14) Ports 1 to 3 take their data byte from the upper byte of words 53h, 55h, 57h.
// (RQ15) Port 0 PHY word sits at 40h, further ports at successive even words.
// (RQ16) All words are loaded after reset before the fields serve the link or reads; port_cfg changes as each word loads, only reads wait for cfg_done_q.
// (RQ17) Each word is 16 bits, bit 0 lowest; unmapped fields keep their defaults.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module eplc_loader
  import eplc_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // word reader
  output logic                     ee_rd_req,
  output logic [EADDR_W-1:0]       ee_addr_q,
  input  wire logic                ee_rd_valid,
  input  wire logic [15:0]         ee_rd_data,
  // register port
  input  wire logic [RADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata_q,
  // loaded configuration
  output logic                     cfg_done_q,
  output eplc_port_t [NPORTS-1:0]  port_cfg
);

  // ===========================================================
  // helpers
  function automatic eplc_dec_t decode_word(input logic [EADDR_W-1:0] a);
    eplc_dec_t d;
    logic [7:0] rel;
    d.kind = WK_NONE;
    d.port = '0;
    rel = '0;
    if (a >= EE_PHY_FIRST && a <= EE_PHY_LAST && !a[0]) begin
      rel = a - EE_PHY_FIRST;
      d.kind = WK_PHY; // RQ15
      d.port = rel[PORT_W:1];
    end else if (a >= EE_PM_FIRST && a <= EE_PM_LAST) begin
      rel = a - EE_PM_FIRST;
      d.kind = a[0] ? WK_DATA : WK_PM; // RQ13 RQ14
      d.port = rel[PORT_W:1];
    end
    return d;
  endfunction

  function automatic logic [EADDR_W-1:0] next_word(input logic [EADDR_W-1:0] a);
    if (a == EE_PHY_LAST) begin
      return EE_PM_FIRST;
    end else if (a < EE_PHY_LAST) begin
      return a + EE_PHY_STEP;
    end else begin
      return a + EE_PM_STEP;
    end
  endfunction

  function automatic logic [31:0] cfg_image(input eplc_port_t f,
                                            input logic [OFS_W-1:0] ofs);
    logic [31:0] v;
    v = '0;
    unique case (ofs)
      OFS_PM_CAP: begin
        v[C_AUX_LSB +: 3] = f.aux_cur;
        v[C_D1_SUP]       = 1'b1; // RQ9
        v[C_D2_SUP]       = 1'b1; // RQ10
        v[C_PME_LSB +: 2] = f.pme_d2d1;
      end
      OFS_PM_CSR: begin
        v[C_NSR]           = f.no_soft_rst;
        v[C_DATA_LSB +: 8] = f.pm_data;
      end
      OFS_LINK_CMP: v[C_COMPDET] = f.comp_det;
      OFS_PHY2:     v[C_PHY2_LSB +: 5] = f.phy2;
      OFS_TL_CTRL:  v[C_DCC_LSB +: 2] = f.data_count_change_select;
      OFS_PHY3:     v[C_PHY3_LSB +: 7] = f.phy3;
      OFS_DEEMPH:   v[C_DEEMPH] = f.deemph;
      default:      v = '0; // RQ17
    endcase
    return v;
  endfunction

  // ===========================================================
  // sequencer
  typedef enum logic [1:0] {
    ST_ISSUE,
    ST_WAIT,
    ST_DONE
  } eplc_state_t;

  eplc_state_t state_q;
  eplc_dec_t   cur_dec;
  logic        word_taken;
  logic        reload_req;
  logic [PORT_W-1:0] reg_port;
  logic [OFS_W-1:0]  reg_ofs;

  assign cur_dec    = decode_word(ee_addr_q);
  assign word_taken = (state_q == ST_WAIT) && ee_rd_valid;
  assign ee_rd_req  = (state_q == ST_ISSUE);
  assign reg_port   = reg_addr[RADDR_W-1:OFS_W];
  assign reg_ofs    = reg_addr[OFS_W-1:0];
  assign reload_req = reg_wr && reg_port == LDR_PORT && reg_ofs == OFS_LDR_CTRL
                      && reg_wdata[CTRL_RELOAD];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_ISSUE; // RQ16
    end else if (reload_req) begin
      state_q <= ST_ISSUE;
    end else begin
      unique case (state_q)
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (ee_rd_valid) begin
            state_q <= (ee_addr_q == EE_PM_LAST) ? ST_DONE : ST_ISSUE;
          end
        end
        ST_DONE:  state_q <= ST_DONE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ee_addr_q <= EE_PHY_FIRST;
    end else if (reload_req) begin
      ee_addr_q <= EE_PHY_FIRST;
    end else if (word_taken && ee_addr_q != EE_PM_LAST) begin
      ee_addr_q <= next_word(ee_addr_q); // RQ13
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_done_q <= 1'b0;
    end else if (reload_req) begin
      cfg_done_q <= 1'b0;
    end else if (word_taken && ee_addr_q == EE_PM_LAST) begin
      cfg_done_q <= 1'b1; // RQ16
    end
  end

  // ===========================================================
  // per-port field stores
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic hit;
    assign hit = word_taken && cur_dec.port == PORT_W'(p);
    eplc_port_fields u_fields (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .word     (ee_rd_data), // RQ17
      .ld_phy   (hit && cur_dec.kind == WK_PHY), // RQ6 RQ15
      .ld_pm    (hit && cur_dec.kind == WK_PM), // RQ13
      .ld_data  (hit && cur_dec.kind == WK_DATA), // RQ14
      .fields_q (port_cfg[p])
    );
  end

  // ===========================================================
  // register read port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= '0;
    end else if (!reg_rd) begin
      reg_rdata_q <= '0;
    end else if (reg_port == LDR_PORT) begin
      reg_rdata_q <= '0;
      if (reg_ofs == OFS_LDR_STAT) begin
        reg_rdata_q[STAT_DONE]               <= cfg_done_q;
        reg_rdata_q[STAT_BUSY]               <= !cfg_done_q;
        reg_rdata_q[STAT_ADDR_LSB +: EADDR_W] <= ee_addr_q;
      end
    end else if (!cfg_done_q || reg_port >= PORT_W'(NPORTS)) begin
      reg_rdata_q <= '0; // RQ16
    end else begin
      reg_rdata_q <= cfg_image(port_cfg[reg_port], reg_ofs); // RQ9 RQ10 RQ12
    end
  end

  // ===========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic              chk_phy_q;
  logic              chk_pm_q;
  logic              chk_data_q;
  logic [PORT_W-1:0] chk_port_q;
  logic [15:0]       chk_word_q;
  eplc_port_t        chk_f;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_phy_q  <= 1'b0;
      chk_pm_q   <= 1'b0;
      chk_data_q <= 1'b0;
      chk_port_q <= '0;
      chk_word_q <= '0;
    end else begin
      chk_phy_q  <= word_taken && cur_dec.kind == WK_PHY;
      chk_pm_q   <= word_taken && cur_dec.kind == WK_PM;
      chk_data_q <= word_taken && cur_dec.kind == WK_DATA;
      chk_port_q <= cur_dec.port;
      chk_word_q <= ee_rd_data;
    end
  end

  assign chk_f = port_cfg[chk_port_q];

  // ===========================================================
  // field load checks
  a_phy2_load: assert property (chk_phy_q |-> chk_f.phy2 == chk_word_q[4:0]) // RQ1
    else $error("phy parameter 2 not loaded from word");
  a_phy3_load: assert property (chk_phy_q |-> chk_f.phy3 == chk_word_q[11:5]) // RQ2
    else $error("phy parameter 3 not loaded from word");
  a_deemph_load: assert property (chk_phy_q |-> chk_f.deemph == chk_word_q[12]) // RQ3
    else $error("de-emphasis select not loaded");
  a_comp_det_load: assert property (chk_phy_q |-> chk_f.comp_det == chk_word_q[13]) // RQ4
    else $error("compliance to detect not loaded");
  a_dcc_sel_load: assert property ( // RQ5
      chk_phy_q |-> chk_f.data_count_change_select == chk_word_q[15:14])
    else $error("data count change select not loaded");
  a_port4_phy: assert property ( // RQ6
      ee_addr_q == 8'h48 && word_taken
      |=> port_cfg[4].comp_det == $past(ee_rd_data[13])
      && port_cfg[4].data_count_change_select == $past(ee_rd_data[15:14]))
    else $error("port 4 phy word fields wrong");
  a_nsr_aux_load: assert property ( // RQ7
      chk_pm_q |-> chk_f.no_soft_rst == chk_word_q[0]
      && chk_f.aux_cur == chk_word_q[3:1])
    else $error("no soft reset or aux current wrong");
  a_pme_load: assert property (chk_pm_q |-> chk_f.pme_d2d1 == chk_word_q[7:6]) // RQ11
    else $error("wake support field wrong");
  a_pm_data_load: assert property (chk_data_q |-> chk_f.pm_data == chk_word_q[15:8]) // RQ12
    else $error("power management data byte wrong");
  a_pm_port_map: assert property ( // RQ13
      word_taken && ee_addr_q == 8'h54
      |-> cur_dec.port == 3'd2 && cur_dec.kind == WK_PM)
    else $error("power management word mapped to wrong port");
  // ports 4 and 5 have no power-management words in this map
  a_pm_45_default: assert property ( // RQ17
      port_cfg[4].aux_cur == '0 && port_cfg[4].pm_data == '0
      && port_cfg[5].aux_cur == '0 && port_cfg[5].pm_data == '0)
    else $error("port 4 or 5 power management fields changed");

  // ===========================================================
  // sequencer checks
  a_req_pulse: assert property (ee_rd_req && !reload_req |=> !ee_rd_req) // RQ16
    else $error("word request held longer than one cycle");
  a_addr_hold: assert property ( // RQ16
      state_q == ST_WAIT && !ee_rd_valid && !reload_req |=> $stable(ee_addr_q))
    else $error("word address moved before the answer");
  a_phy_step: assert property ( // RQ15
      word_taken && ee_addr_q < EE_PHY_LAST && !reload_req
      |=> ee_addr_q == $past(ee_addr_q) + EE_PHY_STEP)
    else $error("phy word address did not step by two");
  a_seq_jump: assert property ( // RQ15
      word_taken && ee_addr_q == EE_PHY_LAST && !reload_req
      |=> ee_addr_q == EE_PM_FIRST && ee_rd_req)
    else $error("sequence does not step from phy to pm words");
  a_pm_step: assert property ( // RQ13
      word_taken && ee_addr_q >= EE_PM_FIRST && ee_addr_q != EE_PM_LAST && !reload_req
      |=> ee_addr_q == $past(ee_addr_q) + EE_PM_STEP)
    else $error("pm word address did not step by one");
  a_done_last: assert property ( // RQ16
      word_taken && ee_addr_q == EE_PM_LAST && !reload_req
      |=> cfg_done_q && !ee_rd_req)
    else $error("load not finished after the last word");
  a_done_hold: assert property ( // RQ16
      cfg_done_q && !reload_req |=> cfg_done_q && !ee_rd_req && $stable(port_cfg))
    else $error("fields or done flag moved after the load");
  a_reload_restart: assert property ( // RQ16
      reload_req |=> ee_rd_req && ee_addr_q == EE_PHY_FIRST && !cfg_done_q)
    else $error("reload did not restart from the first word");

  // ===========================================================
  // register port checks
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == '0) // RQ17
    else $error("read data not zero outside a read answer");
  a_d1d2_fixed: assert property ( // RQ9
      reg_rd && cfg_done_q && reg_ofs == OFS_PM_CAP && reg_port < PORT_W'(NPORTS)
      |=> reg_rdata_q[26:25] == 2'b11)
    else $error("D1 or D2 support bit not read as one");
  a_phy_read: assert property ( // RQ1
      reg_rd && cfg_done_q && reg_ofs == OFS_PHY2 && reg_port < PORT_W'(NPORTS)
      |=> reg_rdata_q[C_PHY2_LSB +: 5] == port_cfg[$past(reg_port)].phy2)
    else $error("phy parameter 2 read image wrong");
  a_dcc_read: assert property ( // RQ5
      reg_rd && cfg_done_q && reg_ofs == OFS_TL_CTRL && reg_port < PORT_W'(NPORTS)
      |=> reg_rdata_q[C_DCC_LSB +: 2] == port_cfg[$past(reg_port)].data_count_change_select)
    else $error("data count change select read image wrong");
  a_pm_data_read: assert property ( // RQ12
      reg_rd && cfg_done_q && reg_ofs == OFS_PM_CSR && reg_port < PORT_W'(NPORTS)
      |=> reg_rdata_q[C_DATA_LSB +: 8] == port_cfg[$past(reg_port)].pm_data
      && reg_rdata_q[C_NSR] == port_cfg[$past(reg_port)].no_soft_rst)
    else $error("power management data read image wrong");
  a_status_read: assert property ( // RQ16
      reg_rd && reg_port == LDR_PORT && reg_ofs == OFS_LDR_STAT
      |=> reg_rdata_q[STAT_DONE] == $past(cfg_done_q)
      && reg_rdata_q[STAT_BUSY] == !$past(cfg_done_q)
      && reg_rdata_q[STAT_ADDR_LSB +: EADDR_W] == $past(ee_addr_q))
    else $error("loader status read image wrong");
  a_read_gated: assert property ( // RQ16
      reg_rd && !cfg_done_q && reg_port != LDR_PORT
      |=> reg_rdata_q == '0)
    else $error("field read served before load completes");
  a_unmapped_zero: assert property ( // RQ17
      reg_rd && reg_port < PORT_W'(NPORTS) && reg_ofs == 8'h00
      |=> reg_rdata_q == '0)
    else $error("unmapped offset not read as zero");
  a_port_range: assert property ( // RQ17
      reg_rd && reg_port >= PORT_W'(NPORTS) && reg_port != LDR_PORT
      |=> reg_rdata_q == '0)
    else $error("read of an absent port not zero");

  c_load_done: cover property ($rose(cfg_done_q));
  c_reload: cover property (cfg_done_q && reload_req ##1 ee_rd_req);
  c_pm_data_read: cover property (reg_rd && cfg_done_q && reg_ofs == OFS_PM_CSR
      ##1 reg_rdata_q[31:24] != 8'h00);
  c_status_read: cover property (reg_rd && reg_port == LDR_PORT && reg_ofs == OFS_LDR_STAT);
  c_seq_jump: cover property (word_taken && ee_addr_q == EE_PHY_LAST);

endmodule

`default_nettype wire

// ---- logic/eplc_pkg.sv ----
// eplc_pkg: constants and types shared by the configuration word loader
// assumes: 16-bit configuration words, six switch ports, 100 MHz core clock
package eplc_pkg;

  // ===========================================================
  // sizes
  localparam int unsigned NPORTS  = 6;
  localparam int unsigned PORT_W  = 3;
  localparam int unsigned OFS_W   = 8;
  localparam int unsigned RADDR_W = PORT_W + OFS_W;
  localparam int unsigned EADDR_W = 8;

  // ===========================================================
  // word addresses in the configuration memory
  localparam logic [7:0] EE_PHY_FIRST = 8'h40;
  localparam logic [7:0] EE_PHY_LAST  = 8'h4A;
  localparam logic [7:0] EE_PHY_STEP  = 8'h02;
  localparam logic [7:0] EE_PM_FIRST  = 8'h50;
  localparam logic [7:0] EE_PM_LAST   = 8'h57;
  localparam logic [7:0] EE_PM_STEP   = 8'h01;

  // ===========================================================
  // fields inside a PHY word
  localparam int unsigned W_PHY2_LSB  = 0;
  localparam int unsigned W_PHY2_MSB  = 4;
  localparam int unsigned W_PHY3_LSB  = 5;
  localparam int unsigned W_PHY3_MSB  = 11;
  localparam int unsigned W_DEEMPH    = 12;
  localparam int unsigned W_COMPDET   = 13;
  localparam int unsigned W_DCC_LSB   = 14;
  localparam int unsigned W_DCC_MSB   = 15;

  // fields inside a power-management word
  localparam int unsigned W_NSR       = 0;
  localparam int unsigned W_AUX_LSB   = 1;
  localparam int unsigned W_AUX_MSB   = 3;
  localparam int unsigned W_PME_LSB   = 6;
  localparam int unsigned W_PME_MSB   = 7;
  localparam int unsigned W_DATA_LSB  = 8;
  localparam int unsigned W_DATA_MSB  = 15;

  // ===========================================================
  // configuration offsets and bit positions
  localparam logic [7:0] OFS_PM_CAP   = 8'h40;
  localparam logic [7:0] OFS_PM_CSR   = 8'h44;
  localparam logic [7:0] OFS_LINK_CMP = 8'h78;
  localparam logic [7:0] OFS_PHY2     = 8'h7C;
  localparam logic [7:0] OFS_TL_CTRL  = 8'h8C;
  localparam logic [7:0] OFS_PHY3     = 8'h90;
  localparam logic [7:0] OFS_DEEMPH   = 8'hF0;

  localparam int unsigned C_PHY2_LSB  = 8;
  localparam int unsigned C_PHY3_LSB  = 0;
  localparam int unsigned C_DEEMPH    = 6;
  localparam int unsigned C_COMPDET   = 11;
  localparam int unsigned C_DCC_LSB   = 8;
  localparam int unsigned C_NSR       = 3;
  localparam int unsigned C_AUX_LSB   = 22;
  localparam int unsigned C_D1_SUP    = 25;
  localparam int unsigned C_D2_SUP    = 26;
  localparam int unsigned C_PME_LSB   = 28;
  localparam int unsigned C_DATA_LSB  = 24;

  // ===========================================================
  // loader control and status, in port slot 7
  localparam logic [2:0] LDR_PORT     = 3'h7;
  localparam logic [7:0] OFS_LDR_CTRL = 8'h00;
  localparam logic [7:0] OFS_LDR_STAT = 8'h04;
  localparam int unsigned CTRL_RELOAD = 0;
  localparam int unsigned STAT_DONE   = 0;
  localparam int unsigned STAT_BUSY   = 1;
  localparam int unsigned STAT_ADDR_LSB = 8;

  // ===========================================================
  // per-port loaded fields
  typedef struct packed {
    logic [4:0] phy2;
    logic [6:0] phy3;
    logic       deemph;
    logic       comp_det;
    logic [1:0] data_count_change_select;
    logic       no_soft_rst;
    logic [2:0] aux_cur;
    logic [1:0] pme_d2d1;
    logic [7:0] pm_data;
  } eplc_port_t;

  localparam eplc_port_t PORT_RST = '0;

  typedef enum logic [1:0] {
    WK_NONE,
    WK_PHY,
    WK_PM,
    WK_DATA
  } eplc_kind_t;

  typedef struct packed {
    eplc_kind_t       kind;
    logic [PORT_W-1:0] port;
  } eplc_dec_t;

endpackage

// ---- logic/eplc_port_fields.sv ----
// eplc_port_fields: holds the loaded configuration fields of one port
// assumes: load strobes are one-cycle pulses on clk, one at a time
`timescale 1ns/1ps
`default_nettype none

module eplc_port_fields
  import eplc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // word and load strobes
  input  wire logic [15:0] word,
  input  wire logic        ld_phy,
  input  wire logic        ld_pm,
  input  wire logic        ld_data,
  // loaded fields
  output eplc_port_t       fields_q
);

  // ===========================================================
  // PHY word split
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fields_q.phy2                     <= PORT_RST.phy2;
      fields_q.phy3                     <= PORT_RST.phy3;
      fields_q.deemph                   <= PORT_RST.deemph;
      fields_q.comp_det                 <= PORT_RST.comp_det;
      fields_q.data_count_change_select <= PORT_RST.data_count_change_select;
    end else if (ld_phy) begin
      fields_q.phy2                     <= word[W_PHY2_MSB:W_PHY2_LSB]; // RQ1
      fields_q.phy3                     <= word[W_PHY3_MSB:W_PHY3_LSB]; // RQ2
      fields_q.deemph                   <= word[W_DEEMPH]; // RQ3
      fields_q.comp_det                 <= word[W_COMPDET]; // RQ4
      fields_q.data_count_change_select <= word[W_DCC_MSB:W_DCC_LSB]; // RQ5
    end
  end

  // ===========================================================
  // power-management word split
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fields_q.no_soft_rst <= PORT_RST.no_soft_rst;
      fields_q.aux_cur     <= PORT_RST.aux_cur;
      fields_q.pme_d2d1    <= PORT_RST.pme_d2d1;
    end else if (ld_pm) begin
      fields_q.no_soft_rst <= word[W_NSR]; // RQ7
      fields_q.aux_cur     <= word[W_AUX_MSB:W_AUX_LSB]; // RQ8
      fields_q.pme_d2d1    <= word[W_PME_MSB:W_PME_LSB]; // RQ11
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fields_q.pm_data <= PORT_RST.pm_data;
    end else if (ld_data) begin
      fields_q.pm_data <= word[W_DATA_MSB:W_DATA_LSB]; // RQ12
    end
  end

endmodule

`default_nettype wire

// ---- tb/eplc_ee_model.sv ----
// eplc_ee_model: word store standing in for the configuration memory
// assumes: one request at a time, address held until the answer pulse
`timescale 1ns/1ps
`default_nettype none

module eplc_ee_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // word reader side
  input  wire logic        rd_req,
  input  wire logic [7:0]  addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  logic [15:0] mem [0:255];
  logic [7:0]  log_q [$];
  logic        busy;
  logic [1:0]  wait_n;

  initial begin
    rd_valid = 1'b0;
    rd_data  = 16'h0000;
    busy     = 1'b0;
    wait_n   = 2'h0;
  end

  // ==========================================================
  // answer after 1 to 4 idle cycles, taken from the address
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy     <= 1'b0;
      rd_valid <= 1'b0;
      wait_n   <= 2'h0;
    end else begin
      rd_valid <= 1'b0;
      // data line shows a moving pattern outside the answer cycle
      rd_data  <= ~rd_data;
      if (rd_req && !busy) begin
        busy   <= 1'b1;
        wait_n <= addr[2:1];
        log_q.push_back(addr);
      end else if (busy && wait_n == 2'h0) begin
        busy     <= 1'b0;
        rd_valid <= 1'b1;
        rd_data  <= mem[addr];
      end else if (busy) begin
        wait_n <= wait_n - 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench for the configuration word loader
// assumes: word store model on the reader port, bench as register master
`timescale 1ns/1ps
`default_nettype none

module tb;
  import eplc_pkg::*;

  logic                   clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   ee_rd_req;
  logic [EADDR_W-1:0]     ee_addr_q;
  logic                   ee_rd_valid;
  logic [15:0]            ee_rd_data;
  logic [RADDR_W-1:0]     reg_addr = '0;
  logic [31:0]            reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata_q;
  logic                   cfg_done_q;
  eplc_port_t [NPORTS-1:0] port_cfg;
  int                     n_mismatch = 0;
  int                     cmp_count = 0;
  int                     cyc = 0;

  always #5 clk = ~clk;

  eplc_loader dut_u (
    .clk(clk), .sys_rst(sys_rst), .ee_rd_req(ee_rd_req), .ee_addr_q(ee_addr_q),
    .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .cfg_done_q(cfg_done_q), .port_cfg(port_cfg)
  );

  eplc_ee_model ee_u (
    .clk(clk), .sys_rst(sys_rst), .rd_req(ee_rd_req), .addr(ee_addr_q),
    .rd_valid(ee_rd_valid), .rd_data(ee_rd_data)
  );

  // ==========================================================
  // word contents
  function automatic logic [15:0] phyw(input int p);
    return 16'h9A5C + 16'(p) * 16'h2E17;
  endfunction
  function automatic logic [15:0] pmw(input int p);
    return 16'h00B5 + 16'(p) * 16'h0047;
  endfunction
  function automatic logic [15:0] datw(input int p);
    return 16'h5AC3 + 16'(p) * 16'h2211;
  endfunction

  // ==========================================================
  // reporting and register master
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] p, input logic [7:0] o, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= {p, o};
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] p, input logic [7:0] o, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= {p, o};
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata_q, exp);
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 2000 && cfg_done_q !== 1'b1; i++) @(posedge clk);
    chk({31'h0, cfg_done_q}, 32'h1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_early();
    rdc(3'h5, 8'h7C, 32'h0);
    rdc(3'h0, 8'h40, 32'h0);
  endtask

  task automatic t_order();
    int i;
    chk(32'(ee_u.log_q.size()), 32'd14);
    for (i = 0; i < 14 && i < ee_u.log_q.size(); i++)
      chk(32'(ee_u.log_q[i]), (i < 6) ? 32'h40 + 2 * i : 32'h50 + i - 6);
  endtask

  task automatic t_phy();
    int p;
    logic [15:0] w;
    for (p = 0; p < 6; p++) begin
      w = phyw(p);
      rdc(3'(p), 8'h7C, {19'h0, w[4:0], 8'h00});
      rdc(3'(p), 8'h90, {25'h0, w[11:5]});
      rdc(3'(p), 8'hF0, {25'h0, w[12], 6'h00});
      rdc(3'(p), 8'h78, {20'h0, w[13], 11'h000});
      rdc(3'(p), 8'h8C, {22'h0, w[15:14], 8'h00});
    end
  endtask

  task automatic t_pm();
    int p;
    logic [15:0] w;
    logic [15:0] d;
    for (p = 0; p < 4; p++) begin
      w = pmw(p);
      d = datw(p);
      rdc(3'(p), 8'h40, {2'h0, w[7:6], 1'b0, 2'b11, w[3:1], 22'h0});
      rdc(3'(p), 8'h44, {d[15:8], 20'h0, w[0], 3'h0});
    end
    for (p = 4; p < 6; p++) begin
      rdc(3'(p), 8'h40, 32'h0600_0000);
      rdc(3'(p), 8'h44, 32'h0);
    end
  endtask

  task automatic t_readonly();
    logic [15:0] w;
    logic [15:0] d;
    w = pmw(0);
    d = datw(0);
    wr(3'h0, 8'h40, 32'h0000_0000);
    rdc(3'h0, 8'h40, {2'h0, w[7:6], 1'b0, 2'b11, w[3:1], 22'h0});
    wr(3'h0, 8'h44, 32'h0000_0000);
    rdc(3'h0, 8'h44, {d[15:8], 20'h0, w[0], 3'h0});
  endtask

  task automatic t_unmapped();
    rdc(3'h0, 8'h48, 32'h0);
    rdc(3'h6, 8'h40, 32'h0);
    rdc(3'h2, 8'h7D, 32'h0);
    rdc(3'h1, 8'h00, 32'h0);
  endtask

  task automatic t_reload();
    ee_u.mem[8'h4A] = 16'h63C9;
    ee_u.log_q.delete();
    rdc(LDR_PORT, OFS_LDR_STAT, {16'h0, EE_PM_LAST, 8'h01});
    wr(LDR_PORT, OFS_LDR_CTRL, 32'h1);
    rdc(LDR_PORT, OFS_LDR_STAT, {16'h0, EE_PHY_FIRST, 8'h02});
    rdc(3'h5, 8'h7C, 32'h0);
    wait_done();
    rdc(3'h5, 8'h7C, 32'h0000_0900);
    rdc(3'h5, 8'h8C, 32'h0000_0100);
    t_order();
  endtask

  // ==========================================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    int a;
    for (a = 0; a < 256; a++) ee_u.mem[a] = 16'hFFFF;
    for (a = 0; a < 6; a++) ee_u.mem[8'h40 + 2 * a] = phyw(a);
    for (a = 0; a < 4; a++) ee_u.mem[8'h50 + 2 * a] = pmw(a);
    for (a = 0; a < 4; a++) ee_u.mem[8'h51 + 2 * a] = datw(a);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_early();
    wait_done();
    t_order();
    t_phy();
    t_pm();
    t_readonly();
    t_unmapped();
    t_reload();
    end_of_test();
  end
endmodule

`default_nettype wire
